/* File: dsq_consts.svh */
`ifndef DSQ_CONSTS_SVH
`define DSQ_CONSTS_SVH

// Clock rate and timing
`define DSQ_CLK_PERIOD_PS 4000
`define DSQ_STROBE_GAP_NS 1000
`define DSQ_STROBE_GAP_CYC ((`DSQ_STROBE_GAP_NS * 1000 + `DSQ_CLK_PERIOD_PS - 1) / `DSQ_CLK_PERIOD_PS)

// Holdoff ramp counts
`define DSQ_MIN_RAMPS 2
`define DSQ_MIN_RAMPS_FAST 1
`define DSQ_LEAD_MIN 1
`define DSQ_LEAD_MAX 2

// Trigger source codes {sel2, sel1, sel0}
`define DSQ_SRC_CH1 3'h6
`define DSQ_SRC_CH2 3'h5
`define DSQ_SRC_CH3 3'h2
`define DSQ_SRC_CH4 3'h1
`define DSQ_SRC_LINE 3'h7

// Status register bit positions
`define DSQ_ST_TRIG1 0
`define DSQ_ST_GATE1 1
`define DSQ_ST_TRIG2 2
`define DSQ_ST_GATE2 3
`define DSQ_ST_DELAY 4
`define DSQ_ST_HOLDOFF 5
`define DSQ_ST_TRIG_SEEN 6
`define DSQ_ST_SWEEP_DONE 7
`define DSQ_ST_WIDTH 8

// Intensity scaling shift for reference times number
`define DSQ_DAC_SHIFT 8

`endif

/* File: dsq_pkg.sv */
`default_nettype none
package dsq_pkg;
  typedef enum logic [1:0] {DSQ_HOLDOFF, DSQ_ARMED, DSQ_SWEEP} dsq_state_e;
  typedef logic [2:0] dsq_src_t;
endpackage
`default_nettype wire

/* File: dsq_sequencer.sv */
`include "dsq_consts.svh"
`default_nettype none

// Summary of operation
// - Trigger source changes only during holdoff
// - Tracking mode follows channels unless auto/chop
// - Ramp threshold drives ramp reset low
// - Threshold crossing increments holdoff ramp counter
// - Ramps repeat until counter reaches holdoff count
// - At least two ramps except fastest sweep
// - Count reached drops holdoff, arming sweep
// - First sweep gate rising raises holdoff
// - Delay select picks reference per mode, sequence
// - Status register tracks trigger and sweep activity
// - Each strobe shifts one status bit out
// - Horizontal selects choose intensity composition
// - Added currents scale reference by stored numbers
// - Blank low unblanks, high blanks beam
// - Text window active until lead ramps remain
// - Readout drives all selects high
// - Calibrator tick divided per sweep setting
// - Zoom output switches tenfold magnified gain
// - Text request switches selects to readout three enabled clocks later, after its synchroniser
// - In readout, blank follows text blank input
module dsq_sequencer #(
  parameter int HOLD_CNT_W = 4,
  parameter int NUM_W = 8,
  parameter int CAL_W = 25
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic ramp_at_threshold_in,
  input wire logic first_trigger_seen_n_in,
  input wire logic first_sweep_gate_n_in,
  input wire logic second_trigger_gate_n_in,
  input wire logic second_sweep_gate_n_in,
  input wire logic delay_reached_n_in,
  input wire logic status_shift_strobe_in,
  input wire logic text_request_n_in,
  input wire logic text_blank_in,
  input wire logic [HOLD_CNT_W-1:0] holdoff_count_in,
  input wire logic [1:0] readout_lead_in,
  input wire logic fastest_sweep_in,
  input wire logic channel_tracking_trigger_mode_in,
  input wire logic automatic_level_mode_in,
  input wire logic chop_mode_in,
  input wire logic [3:0] channel_select_in,
  input wire logic [2:0] trig_source_req_in,
  input wire logic horiz_first_req_in,
  input wire logic horiz_second_req_in,
  input wire logic delay_ref_alternate_in,
  input wire logic delay_ref_fixed_in,
  input wire logic chop_blank_in,
  input wire logic [NUM_W-1:0] base_display_intensity_in,
  input wire logic [NUM_W-1:0] text_intensity_in,
  input wire logic [NUM_W-1:0] intensity_reference_current_in,
  input wire logic [NUM_W-1:0] first_sweep_number_in,
  input wire logic [NUM_W-1:0] second_sweep_number_in,
  input wire logic zoom_in,
  input wire logic [CAL_W-1:0] cal_half_period_in,
  output logic sweep_hold_off_out,
  output logic ramp_cycle_reset_n_out,
  output logic [2:0] trig_source_out,
  output logic delay_ref_select_out,
  output logic status_serial_out,
  output logic [NUM_W:0] intensity_current_out,
  output logic blank_out,
  output logic text_window_active_n_out,
  output logic horiz_select_first_out,
  output logic horiz_select_second_out,
  output logic vert_select_ch_one_n_out,
  output logic vert_select_ch_two_n_out,
  output logic vert_select_ch_three_n_out,
  output logic vert_select_ch_four_n_out,
  output logic tenfold_zoom_out,
  output logic calibrator_tick_out
);

  initial begin
    if (HOLD_CNT_W < 2 || NUM_W < 1 || CAL_W < 2) begin
      $error("dsq_sequencer: parameter out of range");
    end
  end

  localparam int NSYNC = 9;
  // Synchronisers start at each pin's idle level so reset release shows no false edge
  localparam logic [NSYNC-1:0] SYNC_IDLE = 9'h0BE;
  localparam int GAP_W = 16;
  localparam logic [GAP_W-1:0] GAP_CYC = GAP_W'(`DSQ_STROBE_GAP_CYC);

  function automatic dsq_pkg::dsq_src_t chan_src(input logic [3:0] sel,
                                                 input dsq_pkg::dsq_src_t dflt);
    dsq_pkg::dsq_src_t s;
    s = dflt;
    if (sel[0]) begin
      s = `DSQ_SRC_CH1;
    end else if (sel[1]) begin
      s = `DSQ_SRC_CH2;
    end else if (sel[2]) begin
      s = `DSQ_SRC_CH3;
    end else if (sel[3]) begin
      s = `DSQ_SRC_CH4;
    end
    return s;
  endfunction

  // Two-stage synchronisers for every asynchronous pin
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  assign async_in = {text_blank_in, text_request_n_in, status_shift_strobe_in,
                     delay_reached_n_in, second_sweep_gate_n_in, second_trigger_gate_n_in,
                     first_sweep_gate_n_in, first_trigger_seen_n_in, ramp_at_threshold_in};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          meta_q[gi] <= SYNC_IDLE[gi];
          sync_q[gi] <= SYNC_IDLE[gi];
        end else if (clk_en_in) begin
          meta_q[gi] <= async_in[gi];
          sync_q[gi] <= meta_q[gi];
        end
      end
    end
  endgenerate

  logic ramp_s, trig1_n_s, gate1_n_s, trig2_n_s, gate2_n_s, delay_n_s, strobe_s, req_n_s, tblank_s;
  assign {tblank_s, req_n_s, strobe_s, delay_n_s, gate2_n_s, trig2_n_s, gate1_n_s, trig1_n_s,
          ramp_s} = sync_q;

  // Edge history
  logic ramp_prev_q, gate1_prev_q, strobe_prev_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ramp_prev_q <= 1'b0;
      gate1_prev_q <= 1'b1;
      strobe_prev_q <= 1'b0;
    end else if (clk_en_in) begin
      ramp_prev_q <= ramp_s;
      gate1_prev_q <= gate1_n_s;
      strobe_prev_q <= strobe_s;
    end
  end
  logic ramp_rise, gate1_rise, gate1_fall, strobe_rise;
  assign ramp_rise = ramp_s & ~ramp_prev_q;
  assign gate1_rise = gate1_n_s & ~gate1_prev_q;
  assign gate1_fall = ~gate1_n_s & gate1_prev_q;
  assign strobe_rise = strobe_s & ~strobe_prev_q;

  // Holdoff target: fastest sweep may use a single ramp
  logic [HOLD_CNT_W-1:0] target;
  logic [HOLD_CNT_W-1:0] min_ramps;
  logic [HOLD_CNT_W-1:0] lead;
  assign min_ramps = fastest_sweep_in ? HOLD_CNT_W'(`DSQ_MIN_RAMPS_FAST)
                                      : HOLD_CNT_W'(`DSQ_MIN_RAMPS);
  assign target = (holdoff_count_in < min_ramps) ? min_ramps : holdoff_count_in;
  assign lead = (readout_lead_in >= 2'(`DSQ_LEAD_MAX)) ? HOLD_CNT_W'(`DSQ_LEAD_MAX)
                                                      : HOLD_CNT_W'(`DSQ_LEAD_MIN);

  dsq_pkg::dsq_state_e state_q;
  logic [HOLD_CNT_W-1:0] ramp_cnt_q;
  logic hold_off_q;
  logic ramp_reset_n_q;

  // Holdoff and sweep sequencing
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= dsq_pkg::DSQ_HOLDOFF;
      ramp_cnt_q <= '0;
      hold_off_q <= 1'b1;
    end else if (clk_en_in) begin
      unique case (state_q)
        dsq_pkg::DSQ_HOLDOFF: begin
          if (ramp_rise) begin
            ramp_cnt_q <= ramp_cnt_q + 1'b1;
            if (ramp_cnt_q + 1'b1 >= target) begin
              state_q <= dsq_pkg::DSQ_ARMED;
              hold_off_q <= 1'b0;
            end
          end
        end
        dsq_pkg::DSQ_ARMED: begin
          if (gate1_fall) begin
            state_q <= dsq_pkg::DSQ_SWEEP;
          end
        end
        dsq_pkg::DSQ_SWEEP: begin
          if (gate1_rise) begin
            state_q <= dsq_pkg::DSQ_HOLDOFF;
            hold_off_q <= 1'b1;
            ramp_cnt_q <= '0;
          end
        end
      endcase
    end
  end

  // Discharge while threshold seen; outside holdoff the capacitor stays discharged
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ramp_reset_n_q <= 1'b0;
    end else if (clk_en_in) begin
      ramp_reset_n_q <= (state_q == dsq_pkg::DSQ_HOLDOFF) && !ramp_rise && !ramp_s;
    end
  end

  // Readout window closes a ramp or two early so text never hides the trigger point
  logic text_win_n_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      text_win_n_q <= 1'b1;
    end else if (clk_en_in) begin
      text_win_n_q <= !((state_q == dsq_pkg::DSQ_HOLDOFF) &&
                        ({1'b0, ramp_cnt_q} + {1'b0, lead} < {1'b0, target}));
    end
  end

  // Trigger source moved only in holdoff; delay reference moved in holdoff or at the sweep end
  logic [2:0] src_q;
  logic dref_q;
  logic tracking;
  assign tracking = channel_tracking_trigger_mode_in && !automatic_level_mode_in &&
                    !chop_mode_in;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_q <= `DSQ_SRC_CH1;
      dref_q <= 1'b0;
    end else if (clk_en_in) begin
      if (state_q == dsq_pkg::DSQ_HOLDOFF) begin
        src_q <= tracking ? chan_src(channel_select_in, trig_source_req_in)
                          : trig_source_req_in;
      end
      if (gate1_rise && state_q == dsq_pkg::DSQ_SWEEP) begin
        dref_q <= delay_ref_alternate_in ? ~dref_q : delay_ref_fixed_in;
      end else if (!delay_ref_alternate_in && state_q == dsq_pkg::DSQ_HOLDOFF) begin
        dref_q <= delay_ref_fixed_in;
      end
    end
  end

  // Status register; sticky bits favour the set over the snapshot clear
  logic [`DSQ_ST_WIDTH-1:0] status_q;
  logic [`DSQ_ST_WIDTH-1:0] shift_q;
  logic [GAP_W-1:0] gap_q;
  logic serial_q;
  logic first_strobe;
  assign first_strobe = strobe_rise && (gap_q >= GAP_CYC);
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_q <= '0;
    end else if (clk_en_in) begin
      status_q[`DSQ_ST_TRIG1] <= ~trig1_n_s;
      status_q[`DSQ_ST_GATE1] <= ~gate1_n_s;
      status_q[`DSQ_ST_TRIG2] <= ~trig2_n_s;
      status_q[`DSQ_ST_GATE2] <= ~gate2_n_s;
      status_q[`DSQ_ST_DELAY] <= ~delay_n_s;
      status_q[`DSQ_ST_HOLDOFF] <= hold_off_q;
      status_q[`DSQ_ST_TRIG_SEEN] <= ~trig1_n_s ||
                                     (status_q[`DSQ_ST_TRIG_SEEN] && !first_strobe);
      status_q[`DSQ_ST_SWEEP_DONE] <= gate1_rise ||
                                      (status_q[`DSQ_ST_SWEEP_DONE] && !first_strobe);
    end
  end

  // Strobe gap marks the start of a fresh read sequence
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      gap_q <= '1;
    end else if (clk_en_in) begin
      if (strobe_rise) begin
        gap_q <= '0;
      end else if (gap_q != '1) begin
        gap_q <= gap_q + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shift_q <= '0;
      serial_q <= 1'b0;
    end else if (clk_en_in) begin
      if (first_strobe) begin
        serial_q <= status_q[0];
        shift_q <= status_q >> 1;
      end else if (strobe_rise) begin
        serial_q <= shift_q[0];
        shift_q <= shift_q >> 1;
      end
    end
  end

  // Display selects, intensity and blanking
  logic readout;
  assign readout = ~req_n_s;
  logic hs1_q, hs2_q, blank_q, zoom_q;
  logic [3:0] vs_n_q;
  logic [NUM_W:0] intensity_current_out_q;
  logic [2*NUM_W-1:0] add1, add2;
  assign add1 = intensity_reference_current_in * first_sweep_number_in;
  assign add2 = intensity_reference_current_in * second_sweep_number_in;
  logic hs1_d, hs2_d;
  assign hs1_d = readout | horiz_first_req_in;
  assign hs2_d = readout | horiz_second_req_in;

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hs1_q <= 1'b0;
      hs2_q <= 1'b0;
      vs_n_q <= '1;
      blank_q <= 1'b1;
      zoom_q <= 1'b0;
    end else if (clk_en_in) begin
      hs1_q <= hs1_d;
      hs2_q <= hs2_d;
      vs_n_q <= readout ? 4'hF : ~channel_select_in;
      blank_q <= readout ? tblank_s : chop_blank_in;
      zoom_q <= zoom_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      intensity_current_out_q <= '0;
    end else if (clk_en_in) begin
      unique case ({hs1_d, hs2_d})
        2'h0: intensity_current_out_q <= {1'b0, base_display_intensity_in};
        2'h1: intensity_current_out_q <= {1'b0, base_display_intensity_in} +
                          {1'b0, add1[`DSQ_DAC_SHIFT +: NUM_W]};
        2'h2: intensity_current_out_q <= {1'b0, base_display_intensity_in} +
                          {1'b0, add2[`DSQ_DAC_SHIFT +: NUM_W]};
        2'h3: intensity_current_out_q <= {1'b0, text_intensity_in};
      endcase
    end
  end

  // Calibrator: square wave, half period set per sweep speed
  logic [CAL_W-1:0] cal_cnt_q;
  logic cal_q;
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cal_cnt_q <= '0;
      cal_q <= 1'b0;
    end else if (clk_en_in) begin
      if (cal_cnt_q + 1'b1 >= cal_half_period_in) begin
        cal_cnt_q <= '0;
        cal_q <= ~cal_q;
      end else begin
        cal_cnt_q <= cal_cnt_q + 1'b1;
      end
    end
  end

  assign sweep_hold_off_out = hold_off_q;
  assign ramp_cycle_reset_n_out = ramp_reset_n_q;
  assign trig_source_out = src_q;
  assign delay_ref_select_out = dref_q;
  assign status_serial_out = serial_q;
  assign intensity_current_out = intensity_current_out_q;
  assign blank_out = blank_q;
  assign text_window_active_n_out = text_win_n_q;
  assign horiz_select_first_out = hs1_q;
  assign horiz_select_second_out = hs2_q;
  assign {vert_select_ch_four_n_out, vert_select_ch_three_n_out,
          vert_select_ch_two_n_out, vert_select_ch_one_n_out} = vs_n_q;
  assign tenfold_zoom_out = zoom_q;
  assign calibrator_tick_out = cal_q;

  a_src_holdoff_only: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (clk_en_in && $past(state_q) != dsq_pkg::DSQ_HOLDOFF) |-> $stable(src_q))
    else $error("trigger source changed outside holdoff");
  a_ramp_reset_low: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (clk_en_in && ramp_rise) |=> !ramp_cycle_reset_n_out)
    else $error("ramp reset not driven low at threshold");
  a_count_increments: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (clk_en_in && ramp_rise && state_q == dsq_pkg::DSQ_HOLDOFF) |=>
    ramp_cnt_q == $past(ramp_cnt_q) + 1'b1 || state_q == dsq_pkg::DSQ_ARMED)
    else $error("ramp counter did not step");
  a_holdoff_min_ramps: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    ($fell(hold_off_q) && !$past(fastest_sweep_in)) |->
    ramp_cnt_q >= HOLD_CNT_W'(`DSQ_MIN_RAMPS))
    else $error("holdoff ended before two ramps");
  a_holdoff_rises: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (clk_en_in && gate1_rise && state_q == dsq_pkg::DSQ_SWEEP) |=>
    sweep_hold_off_out && ramp_cnt_q == '0)
    else $error("holdoff not raised at sweep end");
  a_window_closed: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !hold_off_q |=> text_window_active_n_out)
    else $error("text window open outside holdoff");
  a_readout_selects: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (clk_en_in && readout) |=> horiz_select_first_out && horiz_select_second_out &&
    vs_n_q == 4'hF && blank_out == $past(tblank_s))
    else $error("readout did not take the selects");
  a_shift_one_bit: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (clk_en_in && strobe_rise && !first_strobe) |=> status_serial_out == $past(shift_q[0]))
    else $error("strobe did not shift the next bit");

endmodule

`default_nettype wire

/* File: dsq_far_side.sv */
`default_nettype none
module dsq_far_side #(
  parameter int CHARGE = 6,
  parameter int SWEEP = 30
) (
  input wire logic mclk_in,
  input wire logic hold_off_in,
  input wire logic ramp_reset_n_in,
  input wire logic stall_in,
  input wire logic run_after_delay_in,
  output logic ramp_at_threshold_out,
  output logic first_trigger_seen_n_out,
  output logic first_sweep_gate_n_out,
  output logic second_trigger_gate_n_out,
  output logic second_sweep_gate_n_out,
  output logic delay_reached_n_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int rc = 0;
  int sc = 0;
  initial begin
    ramp_at_threshold_out = 1'b0;
    {first_trigger_seen_n_out, first_sweep_gate_n_out} = 2'h3;
    {second_trigger_gate_n_out, second_sweep_gate_n_out, delay_reached_n_out} = 3'h7;
  end
  // Stall freezes the ramp so the device stays in holdoff
  always @(negedge mclk_in) begin
    if (!ramp_reset_n_in) begin
      rc <= 0;
      ramp_at_threshold_out <= 1'b0;
    end else if (hold_off_in && !stall_in && rc < CHARGE) begin
      rc <= rc + 1;
      ramp_at_threshold_out <= (rc == CHARGE - 1);
    end
  end
  always @(negedge mclk_in) begin
    if (hold_off_in) begin
      sc <= 0;
      {first_trigger_seen_n_out, first_sweep_gate_n_out} <= 2'h3;
      {second_trigger_gate_n_out, second_sweep_gate_n_out, delay_reached_n_out} <= 3'h7;
    end else if (sc < SWEEP) begin
      sc <= sc + 1;
      if (sc == 4) begin
        first_trigger_seen_n_out <= 1'b0;
        first_sweep_gate_n_out <= 1'b0;
      end
      if (sc == 12) begin
        delay_reached_n_out <= 1'b0;
        if (run_after_delay_in) second_trigger_gate_n_out <= 1'b0;
      end
      if (sc == 16) second_trigger_gate_n_out <= 1'b0;
      if (sc == 17) second_sweep_gate_n_out <= 1'b0;
      if (sc == SWEEP - 1) begin
        first_sweep_gate_n_out <= 1'b1;
        second_sweep_gate_n_out <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: dsq_sequencer_tb_top.sv */
`include "dsq_consts.svh"
`default_nettype none
module dsq_sequencer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst_n = 1'b0, strobe = 1'b0, text_req_n = 1'b1, text_blank = 1'b0;
  logic ramp, trig1_n, gate1_n, tgb_n, sgb_n, dly_n;
  logic [3:0] hcnt = 4'h3, chan = 4'h1, vs_n, vx;
  logic [1:0] lead = 2'h1;
  logic fast = 1'b0, track = 1'b0, automatic_level_mode = 1'b0, chop = 1'b0, stall = 1'b0, rad = 1'b0;
  logic [2:0] src_req = 3'h7, src, src_q = 3'h0;
  logic hf = 1'b0, hs = 1'b0, alt = 1'b0, fixed = 1'b0, chop_blank = 1'b0, zoom = 1'b0;
  logic [7:0] base = 8'h10, tint = 8'h20, intensity_reference_current = 8'h80, n1 = 8'h40, n2 = 8'h08;
  logic [24:0] cal_half = 25'h5;
  logic hold, rr_n, dsel, sout, blank, tw_n, hso1, hso2, z, cal, t0;
  logic [8:0] inten, st;
  logic ramp_q = 1'b0, hold_q = 1'b1, gate_q = 1'b1, win_low = 1'b0, ds_q = 1'b0, hold_chk = 1'b0;
  logic en = 1'b1;
  int fails = 0, compares = 0, ramps = 0, gap = 0, rg = 0, k;

  dsq_sequencer dsq_sequencer_inst (.mclk_in(mclk), .rst_n_in(rst_n), .clk_en_in(en),
    .ramp_at_threshold_in(ramp), .first_trigger_seen_n_in(trig1_n),
    .first_sweep_gate_n_in(gate1_n), .second_trigger_gate_n_in(tgb_n),
    .second_sweep_gate_n_in(sgb_n), .delay_reached_n_in(dly_n),
    .status_shift_strobe_in(strobe), .text_request_n_in(text_req_n),
    .text_blank_in(text_blank), .holdoff_count_in(hcnt), .readout_lead_in(lead),
    .fastest_sweep_in(fast), .channel_tracking_trigger_mode_in(track),
    .automatic_level_mode_in(automatic_level_mode), .chop_mode_in(chop), .channel_select_in(chan),
    .trig_source_req_in(src_req), .horiz_first_req_in(hf), .horiz_second_req_in(hs),
    .delay_ref_alternate_in(alt), .delay_ref_fixed_in(fixed), .chop_blank_in(chop_blank),
    .base_display_intensity_in(base), .text_intensity_in(tint),
    .intensity_reference_current_in(intensity_reference_current), .first_sweep_number_in(n1),
    .second_sweep_number_in(n2), .zoom_in(zoom), .cal_half_period_in(cal_half),
    .sweep_hold_off_out(hold), .ramp_cycle_reset_n_out(rr_n), .trig_source_out(src),
    .delay_ref_select_out(dsel), .status_serial_out(sout), .intensity_current_out(inten),
    .blank_out(blank), .text_window_active_n_out(tw_n), .horiz_select_first_out(hso1),
    .horiz_select_second_out(hso2), .vert_select_ch_one_n_out(vs_n[0]),
    .vert_select_ch_two_n_out(vs_n[1]), .vert_select_ch_three_n_out(vs_n[2]),
    .vert_select_ch_four_n_out(vs_n[3]), .tenfold_zoom_out(z), .calibrator_tick_out(cal));

  dsq_far_side dsq_far_side_inst (.mclk_in(mclk), .hold_off_in(hold), .ramp_reset_n_in(rr_n),
    .stall_in(stall), .run_after_delay_in(rad), .ramp_at_threshold_out(ramp),
    .first_trigger_seen_n_out(trig1_n), .first_sweep_gate_n_out(gate1_n),
    .second_trigger_gate_n_out(tgb_n), .second_sweep_gate_n_out(sgb_n),
    .delay_reached_n_out(dly_n));

  initial begin
    forever #2 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  function automatic int exp_ramps(input logic [3:0] c, input logic f);
    int m = f ? 1 : 2;
    return (int'(c) < m) ? m : int'(c);
  endfunction

  function automatic logic [2:0] exp_src(input logic [3:0] ch);
    if (!track || automatic_level_mode || chop || ch == 4'h0) return src_req;
    if (ch[0]) return `DSQ_SRC_CH1;
    if (ch[1]) return `DSQ_SRC_CH2;
    if (ch[2]) return `DSQ_SRC_CH3;
    return `DSQ_SRC_CH4;
  endfunction

  function automatic logic [8:0] exp_int();
    logic [15:0] a;
    if (!text_req_n || (hf && hs)) return {1'b0, tint};
    if (!hf && !hs) return {1'b0, base};
    a = intensity_reference_current * (hs ? n1 : n2);
    return {1'b0, base} + {1'b0, a[15:8]};
  endfunction

  // Each wait is bounded so a stuck holdoff cannot hang the run
  task automatic wait_hold(input int n);
    repeat (n) begin
      k = 0;
      while (hold && k < 3000) begin @(negedge mclk); k++; end
      while (!hold && k < 3000) begin @(negedge mclk); k++; end
      chk("holdoff_cycle", 1, hold);
    end
  endtask

  task automatic read_status(output logic [8:0] v);
    repeat (300) @(negedge mclk);
    for (int b = 0; b < 9; b++) begin
      strobe = 1'b1;
      repeat (20) @(negedge mclk);
      v[b] = sout;
      strobe = 1'b0;
      repeat (20) @(negedge mclk);
    end
  endtask

  always @(posedge mclk) begin
    ramp_q <= ramp;
    hold_q <= hold;
    gate_q <= gate1_n;
    src_q <= src;
    if (hold && !hold_q) begin
      ramps <= 0;
      win_low <= 1'b0;
    end else if (hold && ramp && !ramp_q) ramps <= ramps + 1;
    if (hold && !tw_n) win_low <= 1'b1;
    if (!hold && !hold_q && src !== src_q) chk("source_in_sweep", src_q, src);
    if (hold && ramp && !ramp_q) rg <= 1;
    else if (rg > 0) rg <= rg + 1;
    if (rg > 0 && (!rr_n || rg > 6)) begin
      chk("ramp_reset", 0, rr_n);
      rg <= 0;
    end
    if (!hold && gate1_n && !gate_q) gap <= 1;
    else if (gap > 0) gap <= gap + 1;
    if (gap > 0 && (hold || gap > 6)) begin
      chk("end_to_holdoff", 1, hold);
      gap <= 0;
    end
    if (!hold && hold_q) begin
      ds_q <= dsel;
      if (hold_chk) begin
        chk("ramps", exp_ramps(hcnt, fast), ramps);
        chk("window_end", 1, tw_n);
        chk("window_low", exp_ramps(hcnt, fast) > ((lead >= 2) ? 2 : 1), win_low);
        chk("source", exp_src(chan), src);
        if (!alt) chk("delay_ref", fixed, dsel);
        else chk("delay_alt", !ds_q, dsel);
      end
    end
  end

  // Whole run needs about 4k clocks
  initial begin
    #200000;
    fails++;
    print_verdict();
  end

  initial begin
    void'($urandom(32'h4310));
    repeat (2) @(negedge mclk);
    chk("rst_hold", 1, hold);
    chk("rst_src", `DSQ_SRC_CH1, src);
    chk("rst_blank", 1, blank);
    chk("rst_window", 1, tw_n);
    chk("rst_vsel", 4'hF, vs_n);
    @(negedge mclk);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      hold_chk = 1'b0;
      hcnt = (i < 3) ? 4'(i) : 4'($urandom_range(2, 6));
      fast = (i == 0);
      lead = 2'($urandom_range(0, 3));
      track = i[0];
      automatic_level_mode = (i == 5);
      chop = (i == 7);
      chan = 4'h1 << $urandom_range(0, 3);
      src_req = 3'($urandom_range(1, 7));
      fixed = i[1];
      alt = (i >= 6);
      rad = i[2];
      wait_hold(2);
      hold_chk = 1'b1;
      wait_hold(2);
    end
    cal_half = 25'($urandom_range(3, 9));
    repeat (20) @(negedge mclk);
    repeat (2) begin
      t0 = cal;
      k = 0;
      while (cal === t0 && k < 50) begin @(negedge mclk); k++; end
    end
    chk("cal_half_period", cal_half, k);
    for (int i = 0; i < 2; i++) begin
      zoom = i[0] ^ 1'b1;
      repeat (6) @(negedge mclk);
      chk("zoom", zoom, z);
    end
    // Clock enable low must freeze every register, including the zoom output
    en = 1'b0;
    zoom = ~zoom;
    repeat (6) @(negedge mclk);
    chk("freeze", !zoom, z);
    en = 1'b1;
    wait_hold(1);
    stall = 1'b1;
    read_status(st);
    chk("status_first", 9'h0E0, st);
    read_status(st);
    chk("status_second", 9'h020, st);
    for (int i = 0; i < 16; i++) begin
      hf = i[0];
      hs = i[1];
      text_req_n = (i < 12);
      {base, tint, intensity_reference_current, n1, n2} = (i == 4) ? {40{1'b1}} : 40'({$urandom, $urandom});
      chan = 4'h1 << i[3:2];
      chop_blank = 1'($urandom);
      text_blank = 1'($urandom);
      vx = text_req_n ? ~chan : 4'hF;
      repeat (5) @(negedge mclk);
      chk("intensity", exp_int(), inten);
      chk("horiz", text_req_n ? {hf, hs} : 2'h3, {hso1, hso2});
      chk("vert", vx, vs_n);
      chk("blank", text_req_n ? chop_blank : text_blank, blank);
    end
    text_req_n = 1'b1;
    stall = 1'b0;
    wait_hold(2);
    print_verdict();
  end
endmodule
`default_nettype wire
